/* pkg/cmrm_pkg.sv */
// Shared constants and types for the mailbox manager and the far node
// Assumes one 50 MHz clock and a synchronous active-low reset
`default_nettype none

package cmrm_pkg;
  // Mailbox geometry
  localparam int MBX_N      = 32;            // Mailboxes in extended mode
  localparam int IDX_W      = 5;             // Mailbox index width
  localparam int ID_W       = 29;            // Extended identifier
  localparam int DLC_W      = 4;             // Data length code
  localparam int TPL_W      = 5;             // Transmit priority level
  localparam int DATA_W     = 64;            // Eight data bytes
  localparam int HALF_W     = 32;            // One CPU word of data
  localparam int FIFO_DEPTH = 16;            // Receive buffer words

  // Message control word layout
  localparam int CTL_DLC_LSB = 0;
  localparam int CTL_RTR_BIT = 4;
  localparam int CTL_TPL_LSB = 8;
  localparam int CTL_W       = CTL_TPL_LSB + TPL_W;

  // Mailbox range masks
  localparam logic [MBX_N-1:0] RANGE_LEGACY = 32'h0000_FFFF;
  localparam logic [MBX_N-1:0] RANGE_FULL   = 32'hFFFF_FFFF;

  // Register addresses on the CPU port
  localparam logic [7:0] ADDR_ENABLE    = 8'h00;
  localparam logic [7:0] ADDR_DIRECTION = 8'h04;
  localparam logic [7:0] ADDR_TRS       = 8'h08;
  localparam logic [7:0] ADDR_TRR       = 8'h0C;
  localparam logic [7:0] ADDR_TA        = 8'h10;
  localparam logic [7:0] ADDR_AA        = 8'h14;
  localparam logic [7:0] ADDR_RMP       = 8'h18;
  localparam logic [7:0] ADDR_RML       = 8'h1C;
  localparam logic [7:0] ADDR_OPC       = 8'h20;
  localparam logic [7:0] ADDR_MASK      = 8'h24;
  localparam logic [7:0] ADDR_MODE      = 8'h28;
  localparam int         RAM_SEL_BIT    = 7;  // Address bit 7 picks mailbox RAM

  // Word within one mailbox RAM slot
  localparam logic [1:0] WORD_ID   = 2'h0;
  localparam logic [1:0] WORD_CTL  = 2'h1;
  localparam logic [1:0] WORD_DLO  = 2'h2;
  localparam logic [1:0] WORD_DHI  = 2'h3;

  // Mode register bits and reset values
  localparam int         MODE_LEGACY_BIT = 0;
  localparam int         MODE_STM_BIT    = 1;
  localparam logic [1:0] MODE_RESET      = 2'h1;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

  // One frame as carried on the link and in the buffer
  typedef struct packed {
    logic [ID_W-1:0]   id;
    logic              rtr;
    logic [DLC_W-1:0]  dlc;
    logic [DATA_W-1:0] data;
  } cmrm_frame_s;
  localparam int FRAME_W = $bits(cmrm_frame_s);

  // Transmit sequencer
  typedef enum logic [0:0] {TX_IDLE, TX_BUSY} cmrm_tx_e;
endpackage : cmrm_pkg

`default_nettype wire

/* pkg/cmrm_link_if.sv */
// Frame-level link between the mailbox manager and another node
// Assumes both ends share sys_clk_in; the bench connects the two modports
`default_nettype none

interface cmrm_link_if;
  // Node to device: data or remote frames, taken on valid and ready
  logic                 n2d_valid;
  logic                 n2d_ready;   // Also the device acknowledge
  cmrm_pkg::cmrm_frame_s n2d_frame;
  // Device to node: held until ack or err
  logic                 d2n_valid;
  cmrm_pkg::cmrm_frame_s d2n_frame;
  logic                 d2n_ack;     // One-cycle acknowledge
  logic                 d2n_err;     // One-cycle error or lost arbitration

  modport dev  (input n2d_valid, n2d_frame, d2n_ack, d2n_err,
                output n2d_ready, d2n_valid, d2n_frame);
  modport node (output n2d_valid, n2d_frame, d2n_ack, d2n_err,
                input n2d_ready, d2n_valid, d2n_frame);
endinterface : cmrm_link_if

`default_nettype wire

/* hw/cmrm_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
// Assumes DEPTH is a power of two; one clock, synchronous reset
`default_nettype none

module cmrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage, no reset needed
  logic [AW:0]      wr_ptr;        // Extra bit tells full from empty
  logic [AW:0]      rd_ptr;
  wire  logic       push;
  wire  logic       pop;
  wire  logic       full;

  assign full          = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out  = ~full;
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in & ~full;
  assign pop           = out_valid_out & out_ready_in;

  // Pointers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge sys_clk_in) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_in;
  end
endmodule : cmrm_fifo

`default_nettype wire

/* hw/cmrm_node.sv */
// Far CAN node: sends user frames to the device and acknowledges its frames
// Assumes the device holds d2n_valid until it sees ack or err
`default_nettype none

module cmrm_node
  import cmrm_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rstn_in,
  // Link
  cmrm_link_if.node         link,
  // User send side
  input  wire logic         usr_tx_valid_in,
  input  wire cmrm_pkg::cmrm_frame_s usr_tx_frame_in,
  output logic              usr_tx_ready_out,
  // User receive side
  output logic              usr_rx_valid_out,
  output cmrm_pkg::cmrm_frame_s usr_rx_frame_out,
  // Fault injection: answer err instead of ack
  input  wire logic         usr_err_in
);
  logic        hold_valid;  // Frame waiting for the device
  cmrm_frame_s hold_frame;
  logic        answered;    // Answer already given this frame

  assign usr_tx_ready_out = ~hold_valid;
  assign link.n2d_valid   = hold_valid;
  assign link.n2d_frame   = hold_frame;

  // Outgoing frame holding register
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      hold_valid <= 1'b0;
      hold_frame <= '0;
    end else if (!hold_valid && usr_tx_valid_in) begin
      hold_valid <= 1'b1;
      hold_frame <= usr_tx_frame_in;
    end else if (hold_valid && link.n2d_ready) begin
      hold_valid <= 1'b0;  // Device took and acknowledged it
    end
  end

  // Answer every device frame once, a cycle after it appears
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      link.d2n_ack     <= 1'b0;
      link.d2n_err     <= 1'b0;
      answered         <= 1'b0;
      usr_rx_valid_out <= 1'b0;
      usr_rx_frame_out <= '0;
    end else begin
      answered         <= link.d2n_valid & ~answered;
      link.d2n_ack     <= link.d2n_valid & ~answered & ~usr_err_in;
      link.d2n_err     <= link.d2n_valid & ~answered & usr_err_in;
      usr_rx_valid_out <= link.d2n_valid & ~answered & ~usr_err_in;
      if (link.d2n_valid && !answered) usr_rx_frame_out <= link.d2n_frame;
    end
  end
endmodule : cmrm_node

`default_nettype wire

/* hw/cmrm_dev.sv */
// Mailbox manager: receive matching, pending and lost flags, transmit requests
// Assumes a CPU port with one-cycle write strobes and a frame-level link
`default_nettype none

// What this block does
// - Masked identifier match, store frame into mailbox
// - Storing a frame sets its pending flag
// - No match: frame dropped, nothing written
// - Search from highest mailbox downward
// - Match on pending mailbox sets lost flag, unless it is below the mailbox stored
// - Unprotected overwrites; protected continues search lower
// - Software clears pending after reading data
// - Receive mailbox with remote bit sends remote
// - Another node must acknowledge outside self-test
// - Every received frame acknowledged outside self-test, match or not
// - Self-test: own acknowledge, internal loopback
// - Enable resets zero; zero frees RAM
// - Enabled mailbox blocks identifier writes
// - Software disables mailbox before changing identifier
// - Direction resets zero; one means receive
// - Request bits: write one sets, zero ignored
// - Request cleared on success or abort
// - Receive mailbox request ignored without remote bit
// - CPU set beats simultaneous hardware clear
// - Legacy mode: pending requests sent highest mailbox first
// - Device sets request to answer remote
// - Extended mode: priority level first, number breaks ties
// - Writing pending one clears pending and lost
module cmrm_dev
  import cmrm_pkg::*;
#(
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Link to the other node
  cmrm_link_if.dev         link,
  // CPU register and mailbox RAM port
  input  wire logic        cpu_wr_in,
  input  wire logic        cpu_rd_in,
  input  wire logic [7:0]  cpu_addr_in,
  input  wire logic [31:0] cpu_wdata_in,
  output logic      [31:0] cpu_rdata_out,
  output logic             cpu_rvalid_out,
  // Status
  output logic             tx_busy_out
);
  // Highest set bit of a mailbox vector
  function automatic logic [IDX_W-1:0] top_idx(input logic [MBX_N-1:0] v);
    top_idx = '0;
    for (int i = 0; i < MBX_N; i++) if (v[i]) top_idx = IDX_W'(i);
  endfunction : top_idx

  // Configuration and status registers
  logic [MBX_N-1:0] enable, direction, transmit_request_bit, ta, aa, receive_pending_flag, message_lost_flag, overwrite_protect_bit;
  logic [ID_W-1:0]  gam;          // One bit marks an identifier bit as don't care
  logic [1:0]       mode;         // Legacy and self-test
  // Mailbox RAM, also plain CPU memory while disabled
  logic [ID_W-1:0]   mb_id   [MBX_N];
  logic [CTL_W-1:0]  mb_ctl  [MBX_N];
  logic [DATA_W-1:0] mb_data [MBX_N];

  // CPU decode
  wire logic             wr_ram = cpu_wr_in & cpu_addr_in[RAM_SEL_BIT];
  wire logic             wr_reg = cpu_wr_in & ~cpu_addr_in[RAM_SEL_BIT];
  wire logic [IDX_W-1:0] ram_idx = cpu_addr_in[IDX_W+1:2];
  wire logic [1:0]       ram_word = cpu_addr_in[1:0];
  wire logic [MBX_N-1:0] trs_wr = (wr_reg && cpu_addr_in == ADDR_TRS) ? cpu_wdata_in : '0;
  wire logic [MBX_N-1:0] trr_wr = (wr_reg && cpu_addr_in == ADDR_TRR) ? cpu_wdata_in : '0;
  wire logic [MBX_N-1:0] rmp_wr = (wr_reg && cpu_addr_in == ADDR_RMP) ? cpu_wdata_in : '0;
  wire logic [MBX_N-1:0] ta_wr  = (wr_reg && cpu_addr_in == ADDR_TA) ? cpu_wdata_in : '0;
  wire logic [MBX_N-1:0] aa_wr  = (wr_reg && cpu_addr_in == ADDR_AA) ? cpu_wdata_in : '0;
  wire logic             legacy = mode[MODE_LEGACY_BIT];
  wire logic             self_test_mode    = mode[MODE_STM_BIT];
  // Mailboxes owned by the controller
  wire logic [MBX_N-1:0] active = enable & (legacy ? RANGE_LEGACY : RANGE_FULL);

  // Receive buffer; loopback feeds it in self-test
  cmrm_tx_e              state, next_state;
  cmrm_frame_s           tx_frame, f_frame;
  logic                  fifo_in_ready, f_valid;
  wire logic             fifo_in_valid = self_test_mode ? (state == TX_BUSY) : link.n2d_valid;
  wire cmrm_frame_s      fifo_in_frame = self_test_mode ? tx_frame : link.n2d_frame;
  // Drain stalls while the CPU owns the RAM port
  wire logic             pop = f_valid & ~wr_ram;

  cmrm_fifo #(.WIDTH(FRAME_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (fifo_in_valid),
    .in_data_in    (fifo_in_frame),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (f_valid),
    .out_data_out  (f_frame),
    .out_ready_in  (~wr_ram)
  );
  // Acknowledge is the acceptance itself, never gated by a match
  assign link.n2d_ready = ~self_test_mode & fifo_in_ready;

  // Per-mailbox masked compare and remote bits
  logic [MBX_N-1:0] id_hit, rtr_vec;
  for (genvar g = 0; g < MBX_N; g++) begin : g_mb
    assign id_hit[g]  = ((mb_id[g] ^ f_frame.id) & ~gam) == '0;
    assign rtr_vec[g] = mb_ctl[g][CTL_RTR_BIT];
  end

  // Receive search: stop at first unpending or unprotected hit from the top
  wire logic [MBX_N-1:0] rx_cand = active & direction & id_hit;
  wire logic [MBX_N-1:0] stop    = rx_cand & (~receive_pending_flag | ~overwrite_protect_bit);
  wire logic             have    = |stop;
  wire logic [IDX_W-1:0] sel     = top_idx(stop);
  wire logic [MBX_N-1:0] at_up   = have ? (RANGE_FULL << sel) : RANGE_FULL;
  wire logic             data_in = pop & ~f_frame.rtr;
  wire logic             store   = data_in & have;
  wire logic [MBX_N-1:0] rmp_set = store ? (MBX_N'(1) << sel) : '0;
  wire logic [MBX_N-1:0] rml_set = data_in ? (rx_cand & receive_pending_flag & at_up) : '0;
  // Remote frame hitting a transmit mailbox requests its reply
  wire logic [MBX_N-1:0] rr_set  = (pop & f_frame.rtr) ? (active & ~direction & id_hit) : '0;

  // Transmit choice among eligible mailboxes
  wire logic [MBX_N-1:0] elig = transmit_request_bit & active & (~direction | rtr_vec);
  logic [IDX_W-1:0] pick, cur;
  logic [TPL_W-1:0] pick_tpl;
  logic             found, cancel_cur;
  always_comb begin
    pick     = '0;
    pick_tpl = '0;
    found    = 1'b0;
    // Ascending walk with >= lets the higher number win ties
    for (int i = 0; i < MBX_N; i++) begin
      if (elig[i] && (!found || legacy || mb_ctl[i][CTL_TPL_LSB +: TPL_W] >= pick_tpl)) begin
        pick     = IDX_W'(i);
        pick_tpl = mb_ctl[i][CTL_TPL_LSB +: TPL_W];
        found    = 1'b1;
      end
    end
  end

  // Transmit outcome
  wire logic             busy    = state == TX_BUSY;
  wire logic [MBX_N-1:0] cur_oh  = busy ? (MBX_N'(1) << cur) : '0;
  wire logic             done_ok = busy & (self_test_mode ? fifo_in_ready : link.d2n_ack);
  wire logic             tx_err  = busy & ~self_test_mode & link.d2n_err;
  wire logic             abort   = tx_err & (cancel_cur | trr_wr[cur]);
  wire logic [MBX_N-1:0] trr_idle = trr_wr & transmit_request_bit & ~cur_oh;
  wire logic [MBX_N-1:0] trs_clr = ((done_ok | abort) ? cur_oh : '0) | trr_idle;
  assign link.d2n_valid = busy & ~self_test_mode;
  assign link.d2n_frame = tx_frame;
  assign tx_busy_out    = busy;

  // Sequencer next state; an error without cancel retries after a fresh pick
  always_comb begin
    case (state)
      TX_IDLE: next_state = found ? TX_BUSY : TX_IDLE;
      TX_BUSY: next_state = (done_ok | tx_err) ? TX_IDLE : TX_BUSY;
      default: next_state = TX_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state      <= TX_IDLE;
      cur        <= '0;
      tx_frame   <= '0;
      cancel_cur <= 1'b0;
    end else begin
      state      <= next_state;
      cancel_cur <= busy & ~(done_ok | tx_err) & (cancel_cur | trr_wr[cur]);
      if (state == TX_IDLE && found) begin
        cur      <= pick;
        tx_frame <= '{id: mb_id[pick], rtr: rtr_vec[pick],
                      dlc: mb_ctl[pick][CTL_DLC_LSB +: DLC_W], data: mb_data[pick]};
      end
    end
  end

  // Flag registers: hardware sets win over clears
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      transmit_request_bit <= RESET_WORD;
      ta  <= RESET_WORD;
      aa  <= RESET_WORD;
      receive_pending_flag <= RESET_WORD;
      message_lost_flag <= RESET_WORD;
    end else begin
      transmit_request_bit <= (transmit_request_bit & ~trs_clr) | trs_wr | rr_set;
      ta  <= (ta & ~ta_wr) | (done_ok ? cur_oh : '0);
      aa  <= (aa & ~aa_wr) | (abort ? cur_oh : '0) | trr_idle;
      receive_pending_flag <= (receive_pending_flag & ~rmp_wr) | rmp_set;
      message_lost_flag <= (message_lost_flag & ~rmp_wr) | rml_set;
    end
  end

  // Plain configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      enable    <= RESET_WORD;
      direction <= RESET_WORD;
      overwrite_protect_bit       <= RESET_WORD;
      gam       <= '0;
      mode      <= MODE_RESET;
    end else if (wr_reg) begin
      if (cpu_addr_in == ADDR_ENABLE)    enable    <= cpu_wdata_in;
      if (cpu_addr_in == ADDR_DIRECTION) direction <= cpu_wdata_in;
      if (cpu_addr_in == ADDR_OPC)       overwrite_protect_bit       <= cpu_wdata_in;
      if (cpu_addr_in == ADDR_MASK)      gam       <= cpu_wdata_in[ID_W-1:0];
      if (cpu_addr_in == ADDR_MODE)      mode      <= cpu_wdata_in[1:0];
    end
  end

  // Mailbox RAM: receive store, else CPU write (drain is stalled then)
  always_ff @(posedge sys_clk_in) begin
    if (store) begin
      mb_id[sel]                            <= f_frame.id;
      mb_ctl[sel][CTL_DLC_LSB +: DLC_W]     <= f_frame.dlc;
      mb_data[sel]                          <= f_frame.data;
    end else if (wr_ram) begin
      case (ram_word)
        WORD_ID:  if (!enable[ram_idx]) mb_id[ram_idx] <= cpu_wdata_in[ID_W-1:0];
        WORD_CTL: mb_ctl[ram_idx] <= cpu_wdata_in[CTL_W-1:0];
        WORD_DLO: mb_data[ram_idx][HALF_W-1:0] <= cpu_wdata_in;
        default:  mb_data[ram_idx][DATA_W-1:HALF_W] <= cpu_wdata_in;
      endcase
    end
  end

  // Read selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RESET_WORD;  // Unmapped addresses read zero
    if (cpu_addr_in[RAM_SEL_BIT]) begin
      case (ram_word)
        WORD_ID:  rd_mux = {{(32-ID_W){1'b0}}, mb_id[ram_idx]};
        WORD_CTL: rd_mux = {{(32-CTL_W){1'b0}}, mb_ctl[ram_idx]};
        WORD_DLO: rd_mux = mb_data[ram_idx][HALF_W-1:0];
        default:  rd_mux = mb_data[ram_idx][DATA_W-1:HALF_W];
      endcase
    end else begin
      case (cpu_addr_in)
        ADDR_ENABLE:    rd_mux = enable;
        ADDR_DIRECTION: rd_mux = direction;
        ADDR_TRS:       rd_mux = transmit_request_bit;
        ADDR_TA:        rd_mux = ta;
        ADDR_AA:        rd_mux = aa;
        ADDR_RMP:       rd_mux = receive_pending_flag;
        ADDR_RML:       rd_mux = message_lost_flag;
        ADDR_OPC:       rd_mux = overwrite_protect_bit;
        ADDR_MASK:      rd_mux = {{(32-ID_W){1'b0}}, gam};
        ADDR_MODE:      rd_mux = {30'h0000_0000, mode};
        default:        rd_mux = RESET_WORD;
      endcase
    end
  end

  // Registered read answer one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cpu_rdata_out  <= RESET_WORD;
      cpu_rvalid_out <= 1'b0;
    end else begin
      cpu_rvalid_out <= cpu_rd_in;
      if (cpu_rd_in) cpu_rdata_out <= rd_mux;
    end
  end
endmodule : cmrm_dev

`default_nettype wire

/* tb/cmrm_link_sva.sv */
// Checker for the frame link between device and node
// Assumes one clock and a synchronous active-low reset
`default_nettype none
module cmrm_link_sva
  import cmrm_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  // Node to device
  input wire logic        n2d_valid,
  input wire logic        n2d_ready,
  input wire cmrm_frame_s n2d_frame,
  // Device to node
  input wire logic        d2n_valid,
  input wire cmrm_frame_s d2n_frame,
  input wire logic        d2n_ack,
  input wire logic        d2n_err
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // Frame on offer, no answer yet
  sequence s_wait; d2n_valid && !d2n_ack && !d2n_err; endsequence
  // Node answers in this cycle
  sequence s_done; d2n_ack || d2n_err; endsequence
  frame_hold_a: assert property (s_wait |=> d2n_valid && $stable(d2n_frame))
    else $error("frame not held");
  frame_drop_a: assert property (s_done |=> !d2n_valid)
    else $error("frame not released");
  answer_gate_a: assert property (s_done |-> d2n_valid)
    else $error("answer without frame");
  answer_time_a: assert property ($rose(d2n_valid) |=> s_done)
    else $error("answer late");
  answer_excl_a: assert property (!(d2n_ack && d2n_err))
    else $error("ack and err together");
  ack_pulse_a: assert property (d2n_ack |=> !d2n_ack)
    else $error("ack too long");
  offer_hold_a: assert property (n2d_valid && !n2d_ready |=> n2d_valid && $stable(n2d_frame))
    else $error("offer dropped");
  offer_take_a: assert property (n2d_valid && n2d_ready |=> !n2d_valid)
    else $error("offer repeated");
endmodule : cmrm_link_sva
`default_nettype wire

/* tb/tb_can_mailbox_rx_match_tx_request.sv */
// Bench: device and far node joined by the link
// Assumes package, interface, design and checker compiled first
`default_nettype none
module tb_can_mailbox_rx_match_tx_request;
  timeunit 1ns;
  timeprecision 1ps;
  import cmrm_pkg::*;
  // Bench side of the ports
  logic            sys_clk_in = 1'b0;
  logic            rstn_in = 1'b0;
  logic            wr_s = 1'b0;
  logic            rd_s = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [31:0]     wdata = 32'h0000_0000;
  logic [31:0]     rdata;
  logic            rvalid;
  logic            busy;
  logic            utx_v = 1'b0;
  cmrm_frame_s     utx_f = '0;
  logic            utx_r;
  logic            urx_v;
  cmrm_frame_s     urx_f;
  logic            uerr = 1'b0;
  // Counters, captured frames, random identifiers
  int              failures = 0;
  int              samples_checked = 0;
  cmrm_frame_s     seen[$];
  cmrm_frame_s     f;
  logic [ID_W-1:0] idm, id2, id7;

  cmrm_link_if lnk ();
  cmrm_dev u_cmrm_dev (.sys_clk_in, .rstn_in, .link(lnk), .cpu_wr_in(wr_s), .cpu_rd_in(rd_s),
    .cpu_addr_in(addr), .cpu_wdata_in(wdata), .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid),
    .tx_busy_out(busy));
  cmrm_node u_cmrm_node (.sys_clk_in, .rstn_in, .link(lnk), .usr_tx_valid_in(utx_v),
    .usr_tx_frame_in(utx_f), .usr_tx_ready_out(utx_r), .usr_rx_valid_out(urx_v),
    .usr_rx_frame_out(urx_f), .usr_err_in(uerr));
  cmrm_link_sva u_cmrm_link_sva (.sys_clk_in, .rstn_in, .n2d_valid(lnk.n2d_valid),
    .n2d_ready(lnk.n2d_ready), .n2d_frame(lnk.n2d_frame), .d2n_valid(lnk.d2n_valid),
    .d2n_frame(lnk.d2n_frame), .d2n_ack(lnk.d2n_ack), .d2n_err(lnk.d2n_err));

  // Clock, 20 ns period
  always #10 sys_clk_in = ~sys_clk_in;
  // Record every frame the node acked
  always @(posedge sys_clk_in) if (urx_v === 1'b1) seen.push_back(urx_f);

  // Mailbox RAM byte address
  function automatic logic [7:0] ra(input int n, input logic [1:0] w);
    return {1'b1, 5'(n), w};
  endfunction : ra
  // Data frame with random payload
  function automatic cmrm_frame_s mk(input logic [ID_W-1:0] id);
    return '{id: id, rtr: 1'b0, dlc: 4'h8, data: {$urandom, $urandom}};
  endfunction : mk
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask : check
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // One CPU write, strobe for one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk_in);
    wr_s <= 1'b0;
  endtask : wr
  // One CPU read; answer checked 1 ns after the edge that takes the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk_in);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge sys_clk_in);
    rd_s <= 1'b0;
    #1;
    check({31'h0, rvalid}, 32'h0000_0001, "read answer");
    check(rdata, exp, what);
  endtask : rdc
  // Node user offer, then time for the match
  task automatic send(input cmrm_frame_s x);
    @(posedge sys_clk_in);
    utx_v <= 1'b1;
    utx_f <= x;
    @(posedge sys_clk_in);
    utx_v <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
  endtask : send
  // Bounded wait for k frames at the node
  task automatic wait_seen(input int k);
    for (int n = 0; n < 300 && seen.size() < k; n++) @(posedge sys_clk_in);
    if (seen.size() < k) begin
      failures++;
      $display("mismatch at %0t: frame missing", $time);
      stop_test();
    end
  endtask : wait_seen

  // Main sequence
  initial begin
    void'($urandom(59));
    repeat (4) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rdc(ADDR_ENABLE, RESET_WORD, "enable");
    rdc(ADDR_DIRECTION, RESET_WORD, "direction");
    rdc(ADDR_TRS, RESET_WORD, "request");
    $display("reset test done");
    idm = ID_W'($urandom);
    id2 = ID_W'($urandom);
    id7 = ID_W'($urandom);
    wr(ra(9, WORD_ID), 32'(idm));
    wr(ra(5, WORD_ID), 32'(idm));
    wr(ra(2, WORD_ID), 32'(id2));
    wr(ra(7, WORD_ID), 32'(id7));
    wr(ra(2, WORD_CTL), 32'h0000_0308);
    wr(ra(7, WORD_CTL), 32'h0000_0108);
    wr(ra(5, WORD_CTL), 32'h0000_0008);
    wr(ADDR_MODE, 32'h0000_0000);
    wr(ADDR_OPC, 32'h0000_0200);
    wr(ADDR_DIRECTION, 32'h0000_0220);
    wr(ADDR_ENABLE, 32'h0000_02A4);
    wr(ra(9, WORD_ID), 32'h0000_0000);
    rdc(ra(9, WORD_ID), 32'(idm), "id locked");
    f = mk(idm);
    send(f);
    rdc(ADDR_RMP, 32'h0000_0200, "top first");
    rdc(ra(9, WORD_DHI), f.data[63:32], "stored");
    send(mk(idm));
    rdc(ADDR_RML, 32'h0000_0200, "lost");
    f = mk(idm);
    send(f);
    rdc(ADDR_RMP, 32'h0000_0220, "pending");
    rdc(ra(5, WORD_DLO), f.data[31:0], "overwrite");
    send(mk(idm ^ 29'h1));
    rdc(ADDR_RMP, 32'h0000_0220, "no match");
    wr(ADDR_RMP, 32'h0000_0200);
    rdc(ADDR_RML, 32'h0000_0020, "lost cleared");
    $display("receive test done");
    wr(ADDR_TRS, 32'h0000_0084);
    wait_seen(2);
    check(32'(seen[0].id), 32'(id2), "priority");
    check(32'(seen[1].id), 32'(id7), "order");
    rdc(ADDR_TRS, RESET_WORD, "done");
    rdc(ADDR_TA, 32'h0000_0084, "sent");
    check({31'h0, busy}, 32'h0000_0000, "idle after queue");
    wr(ra(9, WORD_CTL), 32'h0000_0018);
    wr(ADDR_TRS, 32'h0000_0220);
    wait_seen(3);
    check(32'(seen[2].rtr), 32'h0000_0001, "remote");
    repeat (30) @(posedge sys_clk_in);
    check(32'(seen.size()), 32'h0000_0003, "ignored");
    rdc(ADDR_TRS, 32'h0000_0020, "remote cleared");
    wr(ADDR_TRR, 32'h0000_0020);
    rdc(ADDR_AA, 32'h0000_0020, "cancel");
    $display("transmit test done");
    uerr <= 1'b1;
    wr(ADDR_TRS, 32'h0000_0004);
    wr(ADDR_TRR, 32'h0000_0004);
    repeat (10) @(posedge sys_clk_in);
    rdc(ADDR_AA, 32'h0000_0024, "abort");
    rdc(ADDR_TRS, RESET_WORD, "abort clears");
    uerr <= 1'b0;
    $display("abort test done");
    wr(ADDR_MODE, 32'h0000_0002);
    wr(ADDR_RMP, 32'h0000_0220);
    wr(ADDR_TA, 32'h0000_0284);
    wr(ADDR_ENABLE, 32'h0000_02A0);
    wr(ra(2, WORD_ID), 32'(idm));
    wr(ADDR_ENABLE, 32'h0000_02A4);
    send(mk(idm));
    wr(ADDR_TRS, 32'h0000_0004);
    repeat (20) @(posedge sys_clk_in);
    rdc(ADDR_RMP, 32'h0000_0200, "loopback");
    rdc(ADDR_TA, 32'h0000_0004, "own ack");
    check(32'(seen.size()), 32'h0000_0003, "quiet link");
    wr(ADDR_MODE, 32'h0000_0000);
    repeat (10) @(posedge sys_clk_in);
    rdc(ADDR_RMP, 32'h0000_0220, "held frame");
    $display("self-test done");
    stop_test();
  end
endmodule : tb_can_mailbox_rx_match_tx_request
`default_nettype wire
